/* pkg/cvws_defines.vh */
// constants for the cache victim way selection block
// ============================================================================
// Overview of operation
// - 32KB and 16KB caches have 64 ways; the 8KB cache has 32 ways.
// - 32KB cache has 16 sets; 16KB and 8KB caches have 8 sets.
// - lines are 32 bytes; each set holds one line from every way.
// - low five address bits are byte offset; middle bits pick set; rest tag.
// - instruction cache tags use virtual address, data cache uses real address.
// - a cacheable miss fills a way; a valid line there is evicted.
// - caching-inhibited pages never cause a line fill.
// - every set of each cache has its own victim index field.
// - four byte fields per register, chosen by address bits 25:26.
// - on each fill read the field for the way, then increment it.
// - increment past the last allowed way wraps to the first allowed way.
// - software reads and writes all sixteen victim registers; hardware updates them.
// - four groups: instruction normal/transient, data normal/transient.
// - 32KB: sets 0-3,4-7,8-11,12-15 use registers 0 to 3.
// - 8KB and 16KB: sets 0-3 register 0, 4-7 register 1.
// - 8KB uses the low five field bits, others the low six.
// - user attribute one set marks the access transient.
// - normal index runs from normal floor to last way, then wraps.
// - transient index runs from transient floor to ceiling, then wraps.
`ifndef CVWS_DEFINES_VH
`define CVWS_DEFINES_VH

// ============================================================================
// cache size configurations
`define CVWS_CFG_8KB 2'h0
`define CVWS_CFG_16KB 2'h1
`define CVWS_CFG_32KB 2'h2

// ============================================================================
// way index masks and last ways
`define CVWS_IDX_MASK_32W 8'h1F
`define CVWS_IDX_MASK_64W 8'h3F
`define CVWS_LAST_WAY_32W 8'h1F
`define CVWS_LAST_WAY_64W 8'h3F

// ============================================================================
// address layout (verilog bit = 31 - printed bit)
`define CVWS_OFFSET_MSB 4
`define CVWS_SET_LSB 5
`define CVWS_SET_MSB_SMALL 7
`define CVWS_SET_MSB_32KB 8
`define CVWS_TAG_LSB_SMALL 8
`define CVWS_TAG_LSB_32KB 9

// ============================================================================
// victim register groups; register index is {group, number}
`define CVWS_GRP_ICACHE_NORMAL 2'h0
`define CVWS_GRP_ICACHE_TRANSIENT 2'h1
`define CVWS_GRP_DCACHE_NORMAL 2'h2
`define CVWS_GRP_DCACHE_TRANSIENT 2'h3
`define CVWS_VICTIM_RESET 32'h00000000

// ============================================================================
// field positions in victim and limit registers
`define CVWS_FLD_W 8
`define CVWS_FLD_A_LSB 24
`define CVWS_TRANSIENT_FLOOR_LSB 22
`define CVWS_TCEIL_LSB 11
`define CVWS_NORMAL_FLOOR_LSB 0

`endif

/* hw/cvws_field_sel.v */
// set, register, field and tag selection from the fill address
`timescale 1ns/100ps
`include "cvws_defines.vh"

module cvws_field_sel #(
    parameter [1:0] CACHE_CFG = `CVWS_CFG_32KB
) (
    input wire [31:0] ea, // effective address of fill
    input wire [31:0] tag_addr, // address used for the tag
    output reg [3:0] set_idx, // selected set
    output reg [1:0] reg_num, // victim register within group
    output wire [1:0] field_num, // field a..d within register
    output reg [23:0] tag // tag bits, zero extended
);

    // field follows address bits 25:26 in every size
    assign field_num = ea[`CVWS_SET_LSB+1:`CVWS_SET_LSB];

    // set and register selection by cache size
    always @* begin
        if (CACHE_CFG == `CVWS_CFG_32KB) begin
            set_idx = ea[`CVWS_SET_MSB_32KB:`CVWS_SET_LSB];
            reg_num = ea[`CVWS_SET_MSB_32KB:`CVWS_SET_LSB+2];
            tag = {1'b0, tag_addr[31:`CVWS_TAG_LSB_32KB]};
        end else begin
            set_idx = {1'b0, ea[`CVWS_SET_MSB_SMALL:`CVWS_SET_LSB]};
            reg_num = {1'b0, ea[`CVWS_SET_MSB_SMALL]};
            tag = tag_addr[31:`CVWS_TAG_LSB_SMALL];
        end
    end

endmodule

/* hw/cvws_way_next.v */
// victim way and round-robin successor within limit range
`timescale 1ns/100ps
`include "cvws_defines.vh"

module cvws_way_next #(
    parameter [1:0] CACHE_CFG = `CVWS_CFG_32KB
) (
    input wire transient, // transient access
    input wire [7:0] cur, // current victim field
    input wire [31:0] limit, // victim limit register of cache
    output wire [5:0] way, // way to replace
    output wire [7:0] next, // updated field value
    output wire wrapped // increment wrapped to floor
);

    wire [7:0] mask;
    wire [7:0] cur_m;
    wire [7:0] last;
    wire [7:0] floor;

    // only the low five or six field bits select a way
    assign mask = (CACHE_CFG == `CVWS_CFG_8KB) ? `CVWS_IDX_MASK_32W : `CVWS_IDX_MASK_64W;
    assign cur_m = cur & mask;
    assign way = cur_m[5:0];

    // range bounds of this access type
    assign last = transient ? (limit[`CVWS_TCEIL_LSB+7:`CVWS_TCEIL_LSB] & mask) :
        ((CACHE_CFG == `CVWS_CFG_8KB) ? `CVWS_LAST_WAY_32W : `CVWS_LAST_WAY_64W);
    assign floor = transient ? (limit[`CVWS_TRANSIENT_FLOOR_LSB+7:`CVWS_TRANSIENT_FLOOR_LSB] & mask) :
        (limit[`CVWS_NORMAL_FLOOR_LSB+7:`CVWS_NORMAL_FLOOR_LSB] & mask);

    // increment, wrapping past the last allowed way
    assign wrapped = (cur_m >= last);
    assign next = wrapped ? floor : ((cur_m + 8'h01) & mask);

endmodule

/* hw/cvws_victim_select.v */
// victim way selection with sixteen victim index registers
`timescale 1ns/100ps
`include "cvws_defines.vh"

module cvws_victim_select #(
    parameter [1:0] CACHE_CFG = `CVWS_CFG_32KB
) (
    input wire clk, // core clock
    input wire rst_b, // async reset, active low
    input wire spr_wr_en, // victim register write strobe
    input wire spr_rd_en, // victim register read strobe
    input wire [3:0] spr_idx, // victim register index {group,number}
    input wire [31:0] spr_wdata, // write data
    output reg [31:0] spr_rdata, // read data
    output reg spr_rd_ack, // read data valid pulse
    input wire [31:0] icache_victim_limit, // instruction cache limit register
    input wire [31:0] dcache_victim_limit, // data cache limit register
    input wire fill_req, // line fill request pulse
    input wire fill_dcache, // fill is for data cache
    input wire [31:0] fill_ea, // effective (virtual) address
    input wire [31:0] fill_real_addr, // translated address
    input wire fill_inhibited, // caching-inhibited page
    input wire fill_user_attribute_one, // transient page
    input wire [63:0] fill_set_valid, // valid bits of addressed set
    output reg victim_valid, // victim result pulse
    output reg victim_dcache, // result for data cache
    output reg victim_transient, // result used transient group
    output reg [5:0] victim_way, // way to replace
    output reg [3:0] victim_set, // set to fill
    output reg [23:0] victim_tag, // tag for new line
    output reg victim_evict, // victim way held a valid line
    output reg victim_wrapped, // field wrapped to its floor
    output reg fill_skipped, // inhibited request pulse
    output reg limit_error // ceiling below floor level
);

    // ========================================================================
    // helper functions

    // per-field way mask for the configured size
    function [7:0] field_mask;
        input [1:0] cfg;
        begin
            if (cfg == `CVWS_CFG_8KB) begin
                field_mask = `CVWS_IDX_MASK_32W;
            end else begin
                field_mask = `CVWS_IDX_MASK_64W;
            end
        end
    endfunction

    // extract field a..d (a is the most significant byte)
    function [7:0] field_get;
        input [31:0] word;
        input [1:0] fnum;
        begin
            case (fnum)
                2'h0: field_get = word[`CVWS_FLD_A_LSB+7:`CVWS_FLD_A_LSB];
                2'h1: field_get = word[`CVWS_FLD_A_LSB-1:`CVWS_FLD_A_LSB-`CVWS_FLD_W];
                2'h2: field_get = word[`CVWS_FLD_A_LSB-`CVWS_FLD_W-1:`CVWS_FLD_W];
                default: field_get = word[`CVWS_FLD_W-1:0];
            endcase
        end
    endfunction

    // replace field a..d in a word
    function [31:0] field_put;
        input [31:0] word;
        input [1:0] fnum;
        input [7:0] val;
        begin
            field_put = word;
            case (fnum)
                2'h0: field_put[`CVWS_FLD_A_LSB+7:`CVWS_FLD_A_LSB] = val;
                2'h1: field_put[`CVWS_FLD_A_LSB-1:`CVWS_FLD_A_LSB-`CVWS_FLD_W] = val;
                2'h2: field_put[`CVWS_FLD_A_LSB-`CVWS_FLD_W-1:`CVWS_FLD_W] = val;
                default: field_put[`CVWS_FLD_W-1:0] = val;
            endcase
        end
    endfunction

    // masked transient ceiling below masked transient floor
    function limit_bad;
        input [31:0] limit;
        input [7:0] msk;
        begin
            limit_bad = (limit[`CVWS_TCEIL_LSB+7:`CVWS_TCEIL_LSB] & msk) <
                (limit[`CVWS_TRANSIENT_FLOOR_LSB+7:`CVWS_TRANSIENT_FLOOR_LSB] & msk);
        end
    endfunction

    // ========================================================================
    // fill request qualification

    wire fill_go;
    wire fill_transient;
    wire [1:0] fill_group;
    wire [31:0] fill_tag_addr;
    wire [31:0] fill_limit;
    wire [31:0] word_mask;

    // only cacheable pages may fill
    assign fill_go = fill_req & ~fill_inhibited;

    // transient classification from the page attribute
    assign fill_transient = fill_user_attribute_one;

    // group chosen by cache and access type
    assign fill_group = fill_dcache ?
        (fill_transient ? `CVWS_GRP_DCACHE_TRANSIENT : `CVWS_GRP_DCACHE_NORMAL) :
        (fill_transient ? `CVWS_GRP_ICACHE_TRANSIENT : `CVWS_GRP_ICACHE_NORMAL);

    // icache tags virtual, dcache tags real
    assign fill_tag_addr = fill_dcache ? fill_real_addr : fill_ea;

    // limits come from the cache being filled
    assign fill_limit = fill_dcache ? dcache_victim_limit : icache_victim_limit;

    // reserved high field bits never stored
    assign word_mask = {4{field_mask(CACHE_CFG)}};

    // ========================================================================
    // address decode into set, register and field

    wire [3:0] sel_set;
    wire [1:0] sel_reg;
    wire [1:0] sel_field;
    wire [23:0] sel_tag;
    wire [3:0] upd_idx;

    // set and field decode
    cvws_field_sel #(
        .CACHE_CFG(CACHE_CFG)
    ) u_field_sel (
        .ea(fill_ea),
        .tag_addr(fill_tag_addr),
        .set_idx(sel_set),
        .reg_num(sel_reg),
        .field_num(sel_field),
        .tag(sel_tag)
    );

    // register within the sixteen
    assign upd_idx = {fill_group, sel_reg};

    // ========================================================================
    // victim index registers

    wire [31:0] vic_word [0:15];
    reg [31:0] cur_word;
    wire [7:0] cur_field;
    wire [5:0] nxt_way;
    wire [7:0] nxt_field;
    wire nxt_wrapped;
    wire [31:0] upd_word;

    // select the register addressed by the fill
    always @* begin
        if (upd_idx == 4'h0) begin
            cur_word = vic_word[4'h0];
        end else if (upd_idx == 4'h1) begin
            cur_word = vic_word[4'h1];
        end else if (upd_idx == 4'h2) begin
            cur_word = vic_word[4'h2];
        end else if (upd_idx == 4'h3) begin
            cur_word = vic_word[4'h3];
        end else if (upd_idx == 4'h4) begin
            cur_word = vic_word[4'h4];
        end else if (upd_idx == 4'h5) begin
            cur_word = vic_word[4'h5];
        end else if (upd_idx == 4'h6) begin
            cur_word = vic_word[4'h6];
        end else if (upd_idx == 4'h7) begin
            cur_word = vic_word[4'h7];
        end else if (upd_idx == 4'h8) begin
            cur_word = vic_word[4'h8];
        end else if (upd_idx == 4'h9) begin
            cur_word = vic_word[4'h9];
        end else if (upd_idx == 4'hA) begin
            cur_word = vic_word[4'hA];
        end else if (upd_idx == 4'hB) begin
            cur_word = vic_word[4'hB];
        end else if (upd_idx == 4'hC) begin
            cur_word = vic_word[4'hC];
        end else if (upd_idx == 4'hD) begin
            cur_word = vic_word[4'hD];
        end else if (upd_idx == 4'hE) begin
            cur_word = vic_word[4'hE];
        end else begin
            cur_word = vic_word[4'hF];
        end
    end

    // read the addressed field
    assign cur_field = field_get(cur_word, sel_field);

    // pick the way and its successor
    cvws_way_next #(
        .CACHE_CFG(CACHE_CFG)
    ) u_way_next (
        .transient(fill_transient),
        .cur(cur_field),
        .limit(fill_limit),
        .way(nxt_way),
        .next(nxt_field),
        .wrapped(nxt_wrapped)
    );

    // new register value after increment
    assign upd_word = field_put(cur_word, sel_field, nxt_field);

    // one register per group and number
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_vic
            reg [31:0] vic_q;
            wire sw_hit;
            wire hw_hit;

            assign sw_hit = spr_wr_en & ({28'h0000000, spr_idx} == gi);
            assign hw_hit = fill_go & ({28'h0000000, upd_idx} == gi);
            assign vic_word[gi] = vic_q;

            // software write wins over same-cycle fill update
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    vic_q <= `CVWS_VICTIM_RESET;
                end else if (sw_hit) begin
                    vic_q <= spr_wdata & word_mask;
                end else if (hw_hit) begin
                    vic_q <= upd_word;
                end
            end
        end
    endgenerate

    // ========================================================================
    // register read port

    reg [31:0] rd_word;

    // read data selection by software index
    // a read in a write cycle returns the old word
    always @* begin
        if (spr_idx == 4'h0) begin
            rd_word = vic_word[4'h0];
        end else if (spr_idx == 4'h1) begin
            rd_word = vic_word[4'h1];
        end else if (spr_idx == 4'h2) begin
            rd_word = vic_word[4'h2];
        end else if (spr_idx == 4'h3) begin
            rd_word = vic_word[4'h3];
        end else if (spr_idx == 4'h4) begin
            rd_word = vic_word[4'h4];
        end else if (spr_idx == 4'h5) begin
            rd_word = vic_word[4'h5];
        end else if (spr_idx == 4'h6) begin
            rd_word = vic_word[4'h6];
        end else if (spr_idx == 4'h7) begin
            rd_word = vic_word[4'h7];
        end else if (spr_idx == 4'h8) begin
            rd_word = vic_word[4'h8];
        end else if (spr_idx == 4'h9) begin
            rd_word = vic_word[4'h9];
        end else if (spr_idx == 4'hA) begin
            rd_word = vic_word[4'hA];
        end else if (spr_idx == 4'hB) begin
            rd_word = vic_word[4'hB];
        end else if (spr_idx == 4'hC) begin
            rd_word = vic_word[4'hC];
        end else if (spr_idx == 4'hD) begin
            rd_word = vic_word[4'hD];
        end else if (spr_idx == 4'hE) begin
            rd_word = vic_word[4'hE];
        end else begin
            rd_word = vic_word[4'hF];
        end
    end

    // read data registered one cycle after strobe
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            spr_rdata <= 32'h00000000;
            spr_rd_ack <= 1'b0;
        end else begin
            spr_rd_ack <= spr_rd_en;
            if (spr_rd_en) begin
                spr_rdata <= rd_word;
            end
        end
    end

    // ========================================================================
    // victim result outputs

    // result flops, loaded on each cacheable fill
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            victim_valid <= 1'b0;
            victim_dcache <= 1'b0;
            victim_transient <= 1'b0;
            victim_way <= 6'h00;
            victim_set <= 4'h0;
            victim_tag <= 24'h000000;
            victim_evict <= 1'b0;
            victim_wrapped <= 1'b0;
            fill_skipped <= 1'b0;
        end else begin
            victim_valid <= fill_go;
            fill_skipped <= fill_req & fill_inhibited;
            if (fill_go) begin
                victim_dcache <= fill_dcache;
                victim_transient <= fill_transient;
                victim_way <= nxt_way;
                victim_set <= sel_set;
                victim_tag <= sel_tag;
                victim_evict <= fill_set_valid[nxt_way];
                victim_wrapped <= nxt_wrapped;
            end
        end
    end

    // ========================================================================
    // limit register sanity

    wire [7:0] lim_mask;
    wire i_bad;
    wire d_bad;

    // ceiling below floor is a programming error
    assign lim_mask = field_mask(CACHE_CFG);
    assign i_bad = limit_bad(icache_victim_limit, lim_mask);
    assign d_bad = limit_bad(dcache_victim_limit, lim_mask);

    // registered error level
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            limit_error <= 1'b0;
        end else begin
            limit_error <= i_bad | d_bad;
        end
    end

endmodule

/* test/cvws_victim_select_props.sv */
// assertion checker for the victim way selection block
`timescale 1ns/100ps
`include "cvws_defines.vh"
module cvws_victim_select_props #(
    parameter [1:0] CACHE_CFG = `CVWS_CFG_32KB
) (
    input logic clk, // core clock
    input logic rst_b, // async reset, active low
    input logic spr_rd_en, // read strobe
    input logic spr_rd_ack, // read valid pulse
    input logic fill_req, // fill request
    input logic fill_dcache, // data cache fill
    input logic [31:0] fill_ea, // effective address
    input logic [31:0] fill_real_addr, // translated address
    input logic fill_inhibited, // inhibited page
    input logic fill_user_attribute_one, // transient page
    input logic [63:0] fill_set_valid, // valid bits of set
    input logic victim_valid, // result pulse
    input logic victim_dcache, // result cache
    input logic victim_transient, // result group
    input logic [5:0] victim_way, // way to replace
    input logic [3:0] victim_set, // set to fill
    input logic [23:0] victim_tag, // tag of new line
    input logic victim_evict, // evict flag
    input logic fill_skipped // skip pulse
);
// ============================================================================
// expected set and tag worked out from the request
wire big = (CACHE_CFG == `CVWS_CFG_32KB);
wire [31:0] tag_src = fill_dcache ? fill_real_addr : fill_ea;
wire [3:0] exp_set = big ? fill_ea[8:5] : {1'b0, fill_ea[7:5]};
wire [23:0] exp_tag = big ? {1'b0, tag_src[31:9]} : tag_src[31:8];
wire take = fill_req && !fill_inhibited;
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_b);
// ============================================================================
// properties
property p_rd_ack; spr_rd_en |=> spr_rd_ack; endproperty
a_rd_ack: assert property (p_rd_ack) else $error("read ack missing");
property p_fill_ans; take |=> victim_valid && !fill_skipped; endproperty
a_fill_ans: assert property (p_fill_ans) else $error("fill result missing");
property p_skip; fill_req && fill_inhibited |=> fill_skipped && !victim_valid; endproperty
a_skip: assert property (p_skip) else $error("inhibited fill not skipped");
property p_set; take |=> victim_set == $past(exp_set); endproperty
a_set: assert property (p_set) else $error("wrong set");
property p_tag; take |=> victim_tag == $past(exp_tag); endproperty
a_tag: assert property (p_tag) else $error("wrong tag source");
property p_evict; take |=> (($past(fill_set_valid) >> victim_way) & 64'h1) == {63'h0, victim_evict}; endproperty
a_evict: assert property (p_evict) else $error("evict flag wrong");
property p_group; take |=> {victim_dcache, victim_transient} == $past({fill_dcache, fill_user_attribute_one}); endproperty
a_group: assert property (p_group) else $error("wrong victim group");
property p_hold; !take |=> $stable(victim_way) && $stable(victim_set) && !victim_valid; endproperty
a_hold: assert property (p_hold) else $error("result changed without fill");
endmodule
bind cvws_victim_select cvws_victim_select_props #(.CACHE_CFG(CACHE_CFG)) u_props (.clk(clk), .rst_b(rst_b),
    .spr_rd_en(spr_rd_en), .spr_rd_ack(spr_rd_ack), .fill_req(fill_req), .fill_dcache(fill_dcache),
    .fill_ea(fill_ea), .fill_real_addr(fill_real_addr), .fill_inhibited(fill_inhibited),
    .fill_user_attribute_one(fill_user_attribute_one), .fill_set_valid(fill_set_valid),
    .victim_valid(victim_valid), .victim_dcache(victim_dcache), .victim_transient(victim_transient),
    .victim_way(victim_way), .victim_set(victim_set), .victim_tag(victim_tag),
    .victim_evict(victim_evict), .fill_skipped(fill_skipped));

/* test/cvws_fill_src.sv */
// fill request source standing in for the fetch and load/store pipeline
`timescale 1ns/100ps
module cvws_fill_src (
    input logic clk, // core clock
    output logic fill_req, // request pulse
    output logic fill_dcache, // data cache fill
    output logic [31:0] fill_ea, // effective address
    output logic [31:0] fill_real_addr, // translated address
    output logic fill_inhibited, // inhibited page
    output logic fill_user_attribute_one, // transient page
    output logic [63:0] fill_set_valid // valid bits of set
);
// ============================================================================
// idle values at time zero
initial begin
    fill_req = 1'b0;
    {fill_dcache, fill_inhibited, fill_user_attribute_one} = 3'h0;
    {fill_ea, fill_real_addr, fill_set_valid} = 128'h0;
end
// one fill pulse; addresses and valid bits inverted once the request has been taken
task automatic fill(input logic dc, input logic tr, input logic inh, input logic [31:0] ea);
    @(posedge clk);
    #1;
    fill_req = 1'b1;
    {fill_dcache, fill_user_attribute_one, fill_inhibited} = {dc, tr, inh};
    fill_ea = ea;
    fill_real_addr = ea ^ 32'hFFFF0000;
    fill_set_valid = 64'hAAAAAAAAAAAAAAAA;
    @(posedge clk);
    #1;
    fill_req = 1'b0;
    {fill_ea, fill_real_addr, fill_set_valid} = ~{fill_ea, fill_real_addr, fill_set_valid};
endtask
endmodule

/* test/cvws_victim_select_test.sv */
// self-checking testbench for the victim way selection block
`timescale 1ns/100ps
`include "cvws_defines.vh"
module cvws_victim_select_test;
logic clk = 1'b0;
logic rst_b = 1'b0;
logic spr_wr_en = 1'b0;
logic spr_rd_en = 1'b0;
logic [3:0] spr_idx = 4'h0;
logic [31:0] spr_wdata = 32'h00000000;
logic [31:0] icache_victim_limit = 32'h0100F005;
logic [31:0] dcache_victim_limit = 32'h0200F007;
logic [31:0] spr_rdata, fill_ea, fill_real_addr;
logic [63:0] fill_set_valid;
logic [23:0] victim_tag;
logic [5:0] victim_way;
logic [3:0] victim_set;
logic spr_rd_ack, fill_req, fill_dcache, fill_inhibited, fill_user_attribute_one;
logic victim_valid, victim_dcache, victim_transient, victim_evict, victim_wrapped, fill_skipped, limit_error;
int num_errors = 0;
int num_checks = 0;
always #10 clk = ~clk;
// ============================================================================
// design and pipeline model
cvws_victim_select #(.CACHE_CFG(`CVWS_CFG_32KB)) i_cvws_victim_select (.clk(clk), .rst_b(rst_b),
    .spr_wr_en(spr_wr_en), .spr_rd_en(spr_rd_en), .spr_idx(spr_idx), .spr_wdata(spr_wdata),
    .spr_rdata(spr_rdata), .spr_rd_ack(spr_rd_ack), .icache_victim_limit(icache_victim_limit),
    .dcache_victim_limit(dcache_victim_limit), .fill_req(fill_req), .fill_dcache(fill_dcache),
    .fill_ea(fill_ea), .fill_real_addr(fill_real_addr), .fill_inhibited(fill_inhibited),
    .fill_user_attribute_one(fill_user_attribute_one), .fill_set_valid(fill_set_valid),
    .victim_valid(victim_valid), .victim_dcache(victim_dcache), .victim_transient(victim_transient),
    .victim_way(victim_way), .victim_set(victim_set), .victim_tag(victim_tag),
    .victim_evict(victim_evict), .victim_wrapped(victim_wrapped), .fill_skipped(fill_skipped),
    .limit_error(limit_error));
cvws_fill_src u_src (.clk(clk), .fill_req(fill_req), .fill_dcache(fill_dcache), .fill_ea(fill_ea),
    .fill_real_addr(fill_real_addr), .fill_inhibited(fill_inhibited),
    .fill_user_attribute_one(fill_user_attribute_one), .fill_set_valid(fill_set_valid));
// ============================================================================
// compare, verdict and register access tasks
task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
        num_errors++;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    @(posedge clk);
    #1;
    {spr_wr_en, spr_idx, spr_wdata} = {1'b1, idx, d};
    @(posedge clk);
    #1;
    spr_wr_en = 1'b0;
endtask
task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
    @(posedge clk);
    #1;
    {spr_rd_en, spr_idx} = {1'b1, idx};
    @(posedge clk);
    #1;
    spr_rd_en = 1'b0;
    chk({spr_rd_ack, spr_rdata}, {1'b1, exp});
endtask
// one fill and its result; odd ways hold valid lines
task automatic fl(input logic dc, input logic tr, input logic inh, input logic [31:0] ea,
    input logic [5:0] way, input logic wrap);
    logic [31:0] ta;
    ta = dc ? ea ^ 32'hFFFF0000 : ea;
    u_src.fill(dc, tr, inh, ea);
    chk({victim_valid, fill_skipped}, {!inh, inh});
    if (!inh) chk({victim_dcache, victim_transient, victim_way, victim_wrapped, victim_evict, victim_set,
        victim_tag}, {dc, tr, way, wrap, way[0], ea[8:5], 1'b0,
        ta[31:9]});
endtask
// ============================================================================
// main sequence
initial begin
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 16; i++) rd(i[3:0], 32'h00000000);
    for (int i = 0; i < 16; i++) wr(i[3:0], 32'hF0E1D2C3 + i);
    for (int i = 0; i < 16; i++) rd(i[3:0], (32'hF0E1D2C3 + i) & 32'h3F3F3F3F);
    // normal icache field wraps from the last way to its floor
    wr(4'h0, 32'h3E000000);
    fl(0, 0, 0, 32'h12340000, 6'd62, 1'b0);
    fl(0, 0, 0, 32'h12340000, 6'd63, 1'b1);
    fl(0, 0, 0, 32'h12340000, 6'd5, 1'b0);
    rd(4'h0, 32'h06000000);
    // transient dcache set 13 uses register 3 field b, wraps at the ceiling
    wr(4'hF, 32'h001D0000);
    fl(1, 1, 0, 32'h00ABC1A0, 6'd29, 1'b0);
    fl(1, 1, 0, 32'h00ABC1A0, 6'd30, 1'b1);
    fl(1, 1, 0, 32'h00ABC1A0, 6'd8, 1'b0);
    fl(1, 1, 1, 32'h00ABC1A0, 6'd0, 1'b0);
    rd(4'hF, 32'h00090000);
    // each group advances only its own register
    for (int g = 0; g < 4; g++) wr({g[1:0], 2'h0}, 32'h00000014);
    for (int g = 0; g < 4; g++) fl(g[1], g[0], 0, 32'h00000060, 6'd20, 1'b0);
    for (int g = 0; g < 4; g++) rd({g[1:0], 2'h0}, 32'h00000015);
    // transient ceiling below its floor raises the error level
    chk(limit_error, 1'b0);
    icache_victim_limit = 32'h01000005;
    @(posedge clk);
    #1;
    chk(limit_error, 1'b1);
    icache_victim_limit = 32'h0100F005;
    // second reset clears the fields again
    @(posedge clk);
    #1;
    rst_b = 1'b0;
    @(posedge clk);
    #1;
    rst_b = 1'b1;
    rd(4'hF, 32'h00000000);
    test_done;
end
// watchdog against a hang
initial begin
    #100000;
    num_errors++;
    test_done;
end
endmodule
